//--- design/lpt_defs.vh
// Purpose: Shared constants of the light and proximity threshold interrupt block.
// Assumes: 100 MHz reference clock; command codes select 16-bit words split in a low and a high byte.
// Notes: Definitions only, no logic.
`ifndef LPT_DEFS_VH
`define LPT_DEFS_VH

// Command codes of the 16-bit register words.
`define LPT_CMD_LIGHT_CONF 8'h00
`define LPT_CMD_LIGHT_HIGH_THR 8'h01
`define LPT_CMD_LIGHT_LOW_THR 8'h02
`define LPT_CMD_PROX_CONF 8'h03
`define LPT_CMD_PROX_THR 8'h06
`define LPT_CMD_PROX_RESULT 8'h08
`define LPT_CMD_LIGHT_RESULT 8'h09
`define LPT_CMD_FLAGS 8'h0D

// Field positions in the light configuration low byte.
`define LPT_LIGHT_IT_HI 7
`define LPT_LIGHT_IT_LO 6
`define LPT_LIGHT_PERS_HI 3
`define LPT_LIGHT_PERS_LO 2
`define LPT_LIGHT_IRQ_EN_BIT 1

// Field positions in the proximity configuration word.
`define LPT_DUTY_HI 7
`define LPT_DUTY_LO 6
`define LPT_PROX_PERS_HI 5
`define LPT_PROX_PERS_LO 4
`define LPT_PROX_IRQ_EN_BIT 0
`define LPT_PROX_MODE_BIT 8

// Interrupt flag byte, carried in the high byte of the flag word.
`define LPT_FLAG_PROX_SAT 7
`define LPT_FLAG_SUNLIGHT 6
`define LPT_FLAG_LIGHT_BELOW 5
`define LPT_FLAG_LIGHT_ABOVE 4
`define LPT_FLAG_PROX_CLOSE 1
`define LPT_FLAG_PROX_AWAY 0

// Reset values.
`define LPT_RESET_WORD 16'h0000
`define LPT_RESET_FLAGS 8'h00

// Timing.
`define LPT_CLK_MHZ 100
`define LPT_LIGHT_IT_BASE_MS 50
`define LPT_LIGHT_BASE_CYCLES (`LPT_LIGHT_IT_BASE_MS * 1000 * `LPT_CLK_MHZ)
`define LPT_LUX_STEP_BASE_MLX 8'h18
`define LPT_EMIT_ON_CYCLES 8
`define LPT_EMIT_RATIO_BASE 40

// Serial link.
`define LPT_SLAVE_ADDR 7'h51

`endif

//--- design/lpt_link.v
// Purpose: Serial two-wire slave byte engine sampled by the reference clock.
// Assumes: Link clock well below a quarter of the reference clock rate.
// Notes: Only pulls the data line low; the wire level is resolved outside.
`include "lpt_defs.vh"
module lpt_link #(
  parameter [6:0] SLAVE_ADDR = `LPT_SLAVE_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Link pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe,
  // Byte side
  output reg frame_start,
  output reg wr_valid,
  output reg [7:0] wr_byte,
  output reg rd_load,
  output reg byte_sent,
  input wire [7:0] tx_byte
);

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACK_A = 3'd2;
  localparam S_WRX = 3'd3;
  localparam S_ACK_W = 3'd4;
  localparam S_TX = 3'd5;
  localparam S_ACK_R = 3'd6;
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg scl_p;
  reg sda_p;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg rnw;
  reg host_ack;

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire start_c = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
  wire rise = scl_s & ~scl_p;
  wire fall = ~scl_s & scl_p;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      state <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rnw <= 1'b0;
      host_ack <= 1'b0;
      sda_oe <= 1'b0;
      frame_start <= 1'b0;
      wr_valid <= 1'b0;
      wr_byte <= 8'h00;
      rd_load <= 1'b0;
      byte_sent <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_p <= scl_s;
      sda_p <= sda_s;
      frame_start <= 1'b0;
      wr_valid <= 1'b0;
      rd_load <= 1'b0;
      byte_sent <= 1'b0;
      if (start_c) begin
        state <= S_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
        frame_start <= 1'b1;
      end else if (stop_c) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_WRX: begin
            if (rise && cnt != 4'h8) begin
              sh <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (fall && cnt == 4'h8) begin
              if (state == S_WRX) begin
                wr_valid <= 1'b1;
                wr_byte <= sh;
                sda_oe <= 1'b1;
                state <= S_ACK_W;
              end else if (sh[7:1] == SLAVE_ADDR) begin
                rnw <= sh[0];
                sda_oe <= 1'b1;
                state <= S_ACK_A;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ACK_A, S_ACK_W: begin
            if (fall) begin
              if (state == S_ACK_A && rnw) begin
                sh <= tx_byte;
                sda_oe <= ~tx_byte[7];
                cnt <= 4'h1;
                rd_load <= 1'b1;
                state <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                cnt <= 4'h0;
                state <= S_WRX;
              end
            end
          end
          S_TX: begin
            if (fall) begin
              if (cnt == 4'h8) begin
                sda_oe <= 1'b0;
                byte_sent <= 1'b1;
                state <= S_ACK_R;
              end else begin
                sda_oe <= ~sh[6];
                sh <= {sh[6:0], 1'b0};
                cnt <= cnt + 4'h1;
              end
            end
          end
          S_ACK_R: begin
            if (rise) begin
              host_ack <= ~sda_s;
            end else if (fall) begin
              if (host_ack) begin
                sh <= tx_byte;
                sda_oe <= ~tx_byte[7];
                cnt <= 4'h1;
                rd_load <= 1'b1;
                state <= S_TX;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // lpt_link

//--- design/lpt_persist.v
// Purpose: Consecutive-sample persistence filter for one threshold comparison.
// Assumes: sample_valid is a one-cycle pulse on clk; target is 1 or more.
// Notes: fire pulses one cycle after the sample that completes the run.
module lpt_persist #(
  parameter CW = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Comparison stream
  input wire sample_valid,
  input wire outside,
  input wire [CW-1:0] target,
  // Result
  output reg fire
);

  reg [CW-1:0] run;
  wire [CW-1:0] run_inc = run + {{(CW-1){1'b0}}, 1'b1};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= {CW{1'b0}};
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (sample_valid) begin
        if (!outside) begin
          run <= {CW{1'b0}}; // R20
        end else if (run_inc >= target) begin
          fire <= 1'b1; // R4
          run <= {CW{1'b0}};
        end else begin
          run <= run_inc;
        end
      end
    end
  end

endmodule // lpt_persist

//--- design/lpt_top.v
// Purpose: Threshold, persistence and interrupt logic of a light and proximity sensor, with its register file.
// Assumes: Sample inputs come from the converter logic on ref_clk; link pins are asynchronous.
// Notes: Registers are 16-bit words addressed by a command byte, low byte first on the link.
`include "lpt_defs.vh"

// How it works
// R1 - Light high and low thresholds, byte-written words.
// R2 - Light outside window raises enabled light interrupt.
// R3 - Integration code sets period; halves lux step.
// R4 - Light interrupt needs 1/2/4/8 consecutive outside periods.
// R5 - Separate programmable 8-bit proximity thresholds.
// R6 - Proximity interrupt needs 1/2/3/4 consecutive periods.
// R7 - Every command register reads back its contents.
// R8 - Light result read as one word, low first.
// R9 - One shared low pin, gated by enables.
// R10 - Registers stay accessible while pin asserted.
// R11 - Proximity above high or below low interrupts.
// R12 - Any flag rising pulls the pin low.
// R13 - Reading flags clears them, pin released.
// R14 - Logic mode pin low while object near.
// R15 - Light interrupts on pin need normal mode.
// R16 - Between proximity thresholds, no proximity interrupt.
// R17 - Emitter pulsed at programmable duty ratio.
// R18 - Proximity result read by single register.
// R19 - Flag byte bit layout fixed.
// R20 - Persistence run restarts when back inside.
module lpt_top #(
  parameter [6:0] SLAVE_ADDR = `LPT_SLAVE_ADDR,
  parameter LIGHT_BASE_CYCLES = `LPT_LIGHT_BASE_CYCLES,
  parameter EMIT_ON_CYCLES = `LPT_EMIT_ON_CYCLES,
  parameter EMIT_RATIO_BASE = `LPT_EMIT_RATIO_BASE
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Serial link
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Interrupt pin, open drain
  output wire int_out,
  output reg int_oe,
  // Light converter
  input wire [15:0] light_sample,
  input wire light_sample_valid,
  output reg light_conv_start,
  output reg [7:0] light_step_mlx,
  // Proximity converter
  input wire [7:0] prox_sample,
  input wire prox_sample_valid,
  input wire prox_saturated,
  input wire sunlight_protect,
  output reg prox_conv_start,
  // Emitter
  output reg emitter_drive_pin
);

  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];

  // Register words.
  reg [15:0] light_conf;
  reg [15:0] light_high_threshold;
  reg [15:0] light_low_threshold;
  reg [15:0] prox_conf;
  reg [15:0] prox_thr;
  reg [15:0] light_result;
  reg [7:0] prox_result;
  reg [7:0] flags;

  // Link transaction state.
  reg [7:0] cmd;
  reg [1:0] wcount;
  reg [7:0] wr_lo;
  reg rsel;
  reg [7:0] rd_hi_hold;
  reg [15:0] sel_word;
  reg [7:0] next_flags;

  // Timers.
  reg [31:0] light_timer;
  reg [15:0] emit_timer;

  wire frame_start;
  wire wr_valid;
  wire [7:0] wr_byte;
  wire rd_load;
  wire byte_sent;
  wire light_fire;
  wire prox_fire;

  wire [1:0] light_integration_time = light_conf[`LPT_LIGHT_IT_HI:`LPT_LIGHT_IT_LO];
  wire [1:0] light_persistence_count = light_conf[`LPT_LIGHT_PERS_HI:`LPT_LIGHT_PERS_LO];
  wire light_irq_enable = light_conf[`LPT_LIGHT_IRQ_EN_BIT];
  wire [1:0] emitter_duty_ratio = prox_conf[`LPT_DUTY_HI:`LPT_DUTY_LO];
  wire [1:0] prox_persistence_count = prox_conf[`LPT_PROX_PERS_HI:`LPT_PROX_PERS_LO];
  wire prox_irq_enable = prox_conf[`LPT_PROX_IRQ_EN_BIT];
  wire prox_output_mode_select = prox_conf[`LPT_PROX_MODE_BIT];
  wire [7:0] prox_low_threshold = prox_thr[7:0];
  wire [7:0] prox_high_threshold = prox_thr[15:8];

  // Light targets double per code; proximity targets count up by one.
  function [3:0] light_target;
    input [1:0] code;
    begin
      light_target = 4'h1 << code;
    end
  endfunction

  function [3:0] prox_target;
    input [1:0] code;
    begin
      prox_target = {2'b00, code} + 4'h1;
    end
  endfunction

  // Window test shared by the live light and proximity samples.
  function outside16;
    input [15:0] v;
    input [15:0] hi;
    input [15:0] lo;
    begin
      outside16 = (v > hi) || (v < lo);
    end
  endfunction

  wire light_out_now = outside16(light_sample, light_high_threshold, light_low_threshold); // R2
  wire prox_out_now = outside16({8'h00, prox_sample}, {8'h00, prox_high_threshold},
                                {8'h00, prox_low_threshold}); // R11 R16
  wire light_above = light_result > light_high_threshold;
  wire light_below = light_result < light_low_threshold;
  wire prox_above = prox_result > prox_high_threshold;
  wire prox_below = prox_result < prox_low_threshold;

  wire [31:0] light_period = LIGHT_BASE_CYCLES << light_integration_time; // R3
  wire [31:0] emit_full = (EMIT_ON_CYCLES * EMIT_RATIO_BASE) << emitter_duty_ratio;
  wire [15:0] emit_period = emit_full[15:0];
  assign sda_out = 1'b0;
  assign int_out = 1'b0;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  lpt_link #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_link (
    .clk(ref_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .frame_start(frame_start),
    .wr_valid(wr_valid),
    .wr_byte(wr_byte),
    .rd_load(rd_load),
    .byte_sent(byte_sent),
    .tx_byte(rsel ? rd_hi_hold : sel_word[7:0])
  );

  lpt_persist #(
    .CW(4)
  ) u_light_persist (
    .clk(ref_clk),
    .rst_n(rst_n),
    .sample_valid(light_sample_valid),
    .outside(light_out_now),
    .target(light_target(light_persistence_count)), // R4
    .fire(light_fire)
  );

  lpt_persist #(
    .CW(4)
  ) u_prox_persist (
    .clk(ref_clk),
    .rst_n(rst_n),
    .sample_valid(prox_sample_valid),
    .outside(prox_out_now),
    .target(prox_target(prox_persistence_count)), // R6
    .fire(prox_fire)
  );

  // Readback of every word by command code; unknown codes read zero.
  always @* begin
    case (cmd)
      `LPT_CMD_LIGHT_CONF: sel_word = light_conf; // R7
      `LPT_CMD_LIGHT_HIGH_THR: sel_word = light_high_threshold;
      `LPT_CMD_LIGHT_LOW_THR: sel_word = light_low_threshold;
      `LPT_CMD_PROX_CONF: sel_word = prox_conf;
      `LPT_CMD_PROX_THR: sel_word = prox_thr;
      `LPT_CMD_PROX_RESULT: sel_word = {8'h00, prox_result}; // R18
      `LPT_CMD_LIGHT_RESULT: sel_word = light_result; // R8
      `LPT_CMD_FLAGS: sel_word = {flags, 8'h00};
      default: sel_word = 16'h0000;
    endcase
  end

  // Set wins over clear, so an event landing on the clearing read is kept.
  always @* begin
    next_flags = flags;
    if (byte_sent && rsel && cmd == `LPT_CMD_FLAGS) begin
      next_flags = flags & ~rd_hi_hold; // R13
    end
    if (light_fire && light_irq_enable) begin
      next_flags[`LPT_FLAG_LIGHT_ABOVE] = next_flags[`LPT_FLAG_LIGHT_ABOVE] | light_above; // R19
      next_flags[`LPT_FLAG_LIGHT_BELOW] = next_flags[`LPT_FLAG_LIGHT_BELOW] | light_below;
    end
    if (prox_fire && prox_irq_enable) begin
      next_flags[`LPT_FLAG_PROX_CLOSE] = next_flags[`LPT_FLAG_PROX_CLOSE] | prox_above; // R11
      next_flags[`LPT_FLAG_PROX_AWAY] = next_flags[`LPT_FLAG_PROX_AWAY] | prox_below;
    end
    if (prox_irq_enable) begin
      next_flags[`LPT_FLAG_PROX_SAT] = next_flags[`LPT_FLAG_PROX_SAT] | prox_saturated;
      next_flags[`LPT_FLAG_SUNLIGHT] = next_flags[`LPT_FLAG_SUNLIGHT] | sunlight_protect;
    end
  end

  // Register writes; the link never stalls on interrupt state.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      light_conf <= `LPT_RESET_WORD;
      light_high_threshold <= `LPT_RESET_WORD;
      light_low_threshold <= `LPT_RESET_WORD;
      prox_conf <= `LPT_RESET_WORD;
      prox_thr <= `LPT_RESET_WORD;
      cmd <= 8'h00;
      wcount <= 2'd0;
      wr_lo <= 8'h00;
      rsel <= 1'b0;
      rd_hi_hold <= 8'h00;
    end else begin
      if (frame_start) begin
        wcount <= 2'd0;
        rsel <= 1'b0;
      end
      if (wr_valid) begin // R10
        case (wcount)
          2'd0: begin
            cmd <= wr_byte;
            wcount <= 2'd1;
          end
          2'd1: begin
            wr_lo <= wr_byte;
            wcount <= 2'd2;
          end
          default: begin
            wcount <= 2'd3;
            case (cmd)
              `LPT_CMD_LIGHT_CONF: light_conf <= {wr_byte, wr_lo};
              `LPT_CMD_LIGHT_HIGH_THR: light_high_threshold <= {wr_byte, wr_lo}; // R1
              `LPT_CMD_LIGHT_LOW_THR: light_low_threshold <= {wr_byte, wr_lo};
              `LPT_CMD_PROX_CONF: prox_conf <= {wr_byte, wr_lo};
              `LPT_CMD_PROX_THR: prox_thr <= {wr_byte, wr_lo}; // R5
              default: cmd <= cmd;
            endcase
          end
        endcase
      end
      // The high byte is frozen with the low one so a word read is coherent.
      if (rd_load && !rsel) begin
        rd_hi_hold <= sel_word[15:8]; // R8
      end
      if (byte_sent) begin
        rsel <= ~rsel;
      end
    end
  end

  // Results, flags, timers and pins.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      light_result <= 16'h0000;
      prox_result <= 8'h00;
      flags <= `LPT_RESET_FLAGS;
      int_oe <= 1'b0;
      light_timer <= 32'h00000000;
      emit_timer <= 16'h0000;
      light_conv_start <= 1'b0;
      prox_conv_start <= 1'b0;
      emitter_drive_pin <= 1'b0;
      light_step_mlx <= `LPT_LUX_STEP_BASE_MLX;
    end else begin
      if (light_sample_valid) begin
        light_result <= light_sample;
      end
      if (prox_sample_valid) begin
        prox_result <= prox_sample;
      end
      flags <= next_flags; // R12
      // Logic mode follows the persistence-filtered near/away decision and ignores the flags.
      if (prox_output_mode_select) begin
        if (prox_fire && prox_above) begin
          int_oe <= 1'b1; // R14
        end else if (prox_fire && prox_below) begin
          int_oe <= 1'b0;
        end
      end else begin
        int_oe <= |next_flags; // R9 R15
      end
      light_step_mlx <= `LPT_LUX_STEP_BASE_MLX >> light_integration_time; // R3
      light_conv_start <= 1'b0;
      if (light_timer + 32'h1 >= light_period) begin
        light_timer <= 32'h00000000;
        light_conv_start <= 1'b1;
      end else begin
        light_timer <= light_timer + 32'h1;
      end
      prox_conv_start <= 1'b0;
      if (emit_timer + 16'h1 >= emit_period) begin
        emit_timer <= 16'h0000;
        prox_conv_start <= 1'b1;
      end else begin
        emit_timer <= emit_timer + 16'h1;
      end
      emitter_drive_pin <= emit_timer < EMIT_ON_CYCLES; // R17
    end
  end

endmodule // lpt_top

//--- verif/lpt_checker.sv
// Purpose: Port-level checks of the light and proximity threshold interrupt block.
// Assumes: Sample and event inputs are one-cycle pulses on ref_clk.
// Notes: Bound into lpt_top; sees only its ports.
module lpt_checker #(
  parameter EMIT_ON_CYCLES = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Pins
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire int_out,
  input wire int_oe,
  input wire emitter_drive_pin,
  // Converter side
  input wire light_sample_valid,
  input wire prox_sample_valid,
  input wire prox_saturated,
  input wire sunlight_protect,
  input wire light_conv_start,
  input wire [7:0] light_step_mlx,
  input wire prox_conv_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  int on_cnt;
  always @(posedge ref_clk) on_cnt <= emitter_drive_pin ? on_cnt + 1 : 0;
  // Events may set their flag one cycle sooner than a filtered sample.
  property p_int_cause;
    $rose(int_oe) |-> $past(light_sample_valid, 2) || $past(prox_sample_valid, 2) || $past(prox_saturated, 2)
      || $past(sunlight_protect, 2) || $past(prox_saturated) || $past(sunlight_protect);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("pin asserted with no cause");
  property p_int_release;
    $fell(int_oe) |-> !scl_in || $past(prox_sample_valid, 2);
  endproperty
  a_int_release: assert property (p_int_release) else $error("pin released with no cause");
  property p_emit_width;
    $fell(emitter_drive_pin) |-> on_cnt == EMIT_ON_CYCLES;
  endproperty
  a_emit_width: assert property (p_emit_width) else $error("emitter pulse width wrong");
  property p_step;
    light_step_mlx inside {8'h18, 8'h0C, 8'h06, 8'h03};
  endproperty
  a_step: assert property (p_step) else $error("lux step not a legal value");
  property p_light_start;
    light_conv_start |=> !light_conv_start [*8];
  endproperty
  a_light_start: assert property (p_light_start) else $error("light period too short");
  property p_prox_start;
    prox_conv_start |=> !prox_conv_start [*4];
  endproperty
  a_prox_start: assert property (p_prox_start) else $error("emitter period too short");
  property p_open_drain;
    sda_out == 1'b0 && int_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_sda_edge;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("data changed while link clock high");
  property p_rst_quiet;
    $rose(rstn) |-> !int_oe && !sda_oe ##1 !int_oe && !sda_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
  c_int_set: cover property ($rose(int_oe));
  c_int_clear: cover property ($fell(int_oe) && !scl_in);
  c_emit: cover property ($fell(emitter_drive_pin));
endmodule // lpt_checker

bind lpt_top lpt_checker #(.EMIT_ON_CYCLES(EMIT_ON_CYCLES)) u_chk (.*);

//--- verif/lpt_host.sv
// Purpose: Host model driving the two-wire register link.
// Assumes: Link clock period 160 ns; the data line is pulled up.
// Notes: Link clock stands high between frames.
`include "lpt_defs.vh"
module lpt_host (
  // Link pins
  output logic scl,
  output logic sda_low,
  input wire sda
);
  timeunit 1ns;
  timeprecision 1ps;
  int nacks;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end
  // Data moves mid low phase so the slave never sees it change under a high clock.
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = !b;
    #40 scl = 1'b1;
    #80 r = sda;
    scl = 1'b0;
  endtask
  task automatic start_cond;
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop_cond;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic a;
    byte_io(b, 1'b1, rx, a);
    if (a !== 1'b0)
      nacks++;
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
    start_cond;
    put({`LPT_SLAVE_ADDR, 1'b0});
    put(cmd);
    put(w[7:0]);
    put(w[15:8]);
    stop_cond;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
    logic a;
    start_cond;
    put({`LPT_SLAVE_ADDR, 1'b0});
    put(cmd);
    start_cond;
    put({`LPT_SLAVE_ADDR, 1'b1});
    byte_io(8'hFF, 1'b0, w[7:0], a);
    byte_io(8'hFF, 1'b1, w[15:8], a);
    stop_cond;
  endtask
endmodule // lpt_host

//--- verif/tb_top.sv
// Purpose: Self-checking bench of the light and proximity threshold interrupt block.
// Assumes: Shortened light and emitter periods; host model on the link.
// Notes: Each scenario task drives the block and judges its answers.
`include "lpt_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 100;
  localparam int EON = 2;
  localparam int ERATIO = 4;
  logic ref_clk;
  logic rstn;
  logic [15:0] light_sample;
  logic light_sample_valid;
  logic [7:0] prox_sample;
  logic prox_sample_valid;
  logic prox_saturated;
  logic sunlight_protect;
  wire scl;
  wire host_low;
  wire sda_oe;
  wire int_oe;
  wire emitter_drive_pin;
  wire light_conv_start;
  wire [7:0] light_step_mlx;
  wire sda_line = !(host_low || sda_oe);
  int failures;
  int checks_done;
  lpt_top #(.LIGHT_BASE_CYCLES(BASE), .EMIT_ON_CYCLES(EON), .EMIT_RATIO_BASE(ERATIO)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .int_out(),
    .int_oe(int_oe), .light_sample(light_sample), .light_sample_valid(light_sample_valid),
    .light_conv_start(light_conv_start), .light_step_mlx(light_step_mlx), .prox_sample(prox_sample),
    .prox_sample_valid(prox_sample_valid), .prox_saturated(prox_saturated), .sunlight_protect(sunlight_protect),
    .prox_conv_start(), .emitter_drive_pin(emitter_drive_pin));
  lpt_host u_host (.scl(scl), .sda_low(host_low), .sda(sda_line));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic note(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    note(got, exp);
  endtask
  task automatic chk_b(input logic got, input logic exp);
    note({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_n(input int got, input int exp);
    note(16'(got), 16'(exp));
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] w;
    u_host.read_word(c, w);
    chk_w(w, e);
  endtask
  task automatic smp(input bit px, input logic [15:0] v);
    @(negedge ref_clk);
    light_sample = v;
    prox_sample = v[7:0];
    light_sample_valid = !px;
    prox_sample_valid = px;
    @(negedge ref_clk);
    light_sample_valid = 1'b0;
    prox_sample_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  // The interval after a settings change may still run at the old length, so the next one is measured.
  task automatic period(input bit sel, output int p);
    int n;
    int seen;
    bit prv;
    bit cur;
    n = 0;
    seen = 0;
    prv = 1'b1;
    p = 0;
    for (int i = 0; i < 4000 && seen < 3; i++) begin
      @(negedge ref_clk);
      cur = sel ? emitter_drive_pin : light_conv_start;
      if (cur && !prv) begin
        seen++;
        if (seen == 3)
          p = n;
        n = 0;
      end
      n++;
      prv = cur;
    end
  endtask
  task automatic scen_regs;
    logic [7:0] c [0:4];
    logic [15:0] wv [0:4];
    logic [15:0] ev [0:4];
    c = '{8'h01, 8'h02, 8'h06, 8'h05, 8'h09};
    wv = '{16'h1234, 16'h0102, 16'h8020, 16'hBEEF, 16'h5555};
    ev = '{16'h1234, 16'h0102, 16'h8020, 16'h0000, 16'h0000};
    rd_chk(8'h0D, 16'h0000);
    for (int i = 0; i < 5; i++)
      u_host.write_word(c[i], wv[i]);
    for (int i = 0; i < 5; i++)
      rd_chk(c[i], ev[i]);
  endtask
  task automatic scen_periods;
    int p;
    for (int k = 0; k < 4; k++) begin
      u_host.write_word(8'h00, 16'(k << 6));
      period(1'b0, p);
      chk_n(p, BASE << k);
      chk_w({8'h00, light_step_mlx}, 16'(`LPT_LUX_STEP_BASE_MLX >> k));
      u_host.write_word(8'h03, 16'(k << 6));
      period(1'b1, p);
      chk_n(p, EON * ERATIO << k);
    end
  endtask
  task automatic scen_masked;
    logic [15:0] w;
    u_host.write_word(8'h00, 16'h0000);
    smp(1'b0, 16'hFFFF);
    chk_b(int_oe, 1'b0);
    u_host.read_word(8'h0D, w);
  endtask
  task automatic scen_persist(input bit px, input logic [15:0] outv, input logic [15:0] inv, input int n,
      input logic [15:0] fexp);
    repeat (n - 1) smp(px, outv);
    smp(px, inv);
    repeat (n - 1) smp(px, outv);
    chk_b(int_oe, 1'b0);
    smp(px, outv);
    chk_b(int_oe, 1'b1);
    rd_chk(8'h01, 16'h1234);
    chk_b(int_oe, 1'b1);
    rd_chk(8'h0D, fexp);
    chk_b(int_oe, 1'b0);
    rd_chk(8'h0D, 16'h0000);
  endtask
  task automatic scen_light;
    for (int p = 0; p < 4; p++) begin
      u_host.write_word(8'h00, 16'((p << 2) | 2));
      scen_persist(1'b0, p[0] ? 16'h0101 : 16'h1235, 16'h1234, 1 << p, p[0] ? 16'h2000 : 16'h1000);
    end
  endtask
  task automatic scen_prox;
    for (int c = 0; c < 4; c++) begin
      u_host.write_word(8'h03, 16'((c << 4) | 1));
      scen_persist(1'b1, 16'h0081, 16'h0080, c + 1, 16'h0200);
      scen_persist(1'b1, 16'h001F, 16'h0020, c + 1, 16'h0100);
    end
  endtask
  task automatic scen_events;
    @(negedge ref_clk);
    prox_saturated = 1'b1;
    @(negedge ref_clk);
    prox_saturated = 1'b0;
    sunlight_protect = 1'b1;
    @(negedge ref_clk);
    sunlight_protect = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_b(int_oe, 1'b1);
    rd_chk(8'h0D, 16'hC000);
    chk_b(int_oe, 1'b0);
  endtask
  task automatic scen_logic;
    logic [15:0] w;
    u_host.write_word(8'h03, 16'h0101);
    smp(1'b1, 16'h0081);
    chk_b(int_oe, 1'b1);
    smp(1'b1, 16'h0050);
    chk_b(int_oe, 1'b1);
    smp(1'b1, 16'h001F);
    chk_b(int_oe, 1'b0);
    u_host.read_word(8'h0D, w);
    u_host.write_word(8'h03, 16'h0001);
    u_host.write_word(8'h00, 16'h0002);
    smp(1'b0, 16'h1235);
    chk_b(int_oe, 1'b1);
    rd_chk(8'h0D, 16'h1000);
  endtask
  task automatic scen_results;
    smp(1'b0, 16'h11C3);
    rd_chk(8'h09, 16'h11C3);
    smp(1'b1, 16'h0057);
    rd_chk(8'h08, 16'h0057);
    chk_n(u_host.nacks, 0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    failures = 0;
    checks_done = 0;
    rstn = 1'b0;
    light_sample = 16'h0000;
    light_sample_valid = 1'b0;
    prox_sample = 8'h00;
    prox_sample_valid = 1'b0;
    prox_saturated = 1'b0;
    sunlight_protect = 1'b0;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    scen_regs;
    scen_periods;
    scen_masked;
    scen_light;
    scen_prox;
    scen_events;
    scen_logic;
    scen_results;
    tally_and_finish;
  end
  initial begin
    #1ms;
    failures++;
    tally_and_finish;
  end
endmodule // tb_top
